// ### utab_regs.vh
// Operation codes, condition codes, field positions and reset values for the unsigned datapath.
`ifndef UTAB_REGS_VH
`define UTAB_REGS_VH
// ==========================================================================
// Operation codes
`define UTAB_OP_W 5
`define UTAB_OP_NOP 5'h00
`define UTAB_OP_BYTE_TABLE_BRANCH 5'h01
`define UTAB_OP_HALFWORD_TABLE_BRANCH 5'h02
`define UTAB_OP_PACKED_BYTE_ADD 5'h03
`define UTAB_OP_PACKED_HALF_ADD 5'h04
`define UTAB_OP_ADD_SUB_EXCHANGE 5'h05
`define UTAB_OP_BITFIELD_EXTRACT_ZERO 5'h06
`define UTAB_OP_UNSIGNED_DIVIDE 5'h07
`define UTAB_OP_HALVING_BYTE_ADD 5'h08
`define UTAB_OP_HALVING_HALF_ADD 5'h09
`define UTAB_OP_HALVING_ADD_SUB_EXCHANGE 5'h0a
`define UTAB_OP_HALVING_SUB_ADD_EXCHANGE 5'h0b
`define UTAB_OP_HALVING_BYTE_SUB 5'h0c
`define UTAB_OP_HALVING_HALF_SUB 5'h0d
`define UTAB_OP_DOUBLE_ACCUMULATE_MULTIPLY 5'h0e
`define UTAB_OP_MULTIPLY_ACCUMULATE_LONG 5'h0f
`define UTAB_OP_MULTIPLY_LONG 5'h10
`define UTAB_OP_SATURATING_BYTE_ADD 5'h11
// ==========================================================================
// Condition codes
`define UTAB_CC_EQ 4'h0
`define UTAB_CC_NE 4'h1
`define UTAB_CC_CS 4'h2
`define UTAB_CC_CC 4'h3
`define UTAB_CC_MI 4'h4
`define UTAB_CC_PL 4'h5
`define UTAB_CC_VS 4'h6
`define UTAB_CC_VC 4'h7
`define UTAB_CC_HI 4'h8
`define UTAB_CC_LS 4'h9
`define UTAB_CC_GE 4'ha
`define UTAB_CC_LT 4'hb
`define UTAB_CC_GT 4'hc
`define UTAB_CC_LE 4'hd
// Flag positions inside the four-bit NZCV word.
`define UTAB_FLAG_N 3
`define UTAB_FLAG_Z 2
`define UTAB_FLAG_C 1
`define UTAB_FLAG_V 0
// ==========================================================================
// Constants
`define UTAB_DIV_STEPS 6'h20
`define UTAB_ZERO32 32'h00000000
`define UTAB_ONES32 32'hffffffff
`define UTAB_SAT8 8'hff
`endif

// ### utab_cond.v
// Condition code evaluation against the NZCV flags.
`include "utab_regs.vh"
module utab_cond (
	cond,
	flags,
	pass
);
	input wire [3:0] cond;
	input wire [3:0] flags;
	output reg pass;

	wire n = flags[`UTAB_FLAG_N];
	wire z = flags[`UTAB_FLAG_Z];
	wire c = flags[`UTAB_FLAG_C];
	wire v = flags[`UTAB_FLAG_V];

	// ==========================================================================
	// Decode
	// Codes above LE mean always.
	always @*
	begin
		case (cond)
			`UTAB_CC_EQ: pass = z;
			`UTAB_CC_NE: pass = ~z;
			`UTAB_CC_CS: pass = c;
			`UTAB_CC_CC: pass = ~c;
			`UTAB_CC_MI: pass = n;
			`UTAB_CC_PL: pass = ~n;
			`UTAB_CC_VS: pass = v;
			`UTAB_CC_VC: pass = ~v;
			`UTAB_CC_HI: pass = c & ~z;
			`UTAB_CC_LS: pass = ~c | z;
			`UTAB_CC_GE: pass = (n == v);
			`UTAB_CC_LT: pass = (n != v);
			`UTAB_CC_GT: pass = ~z & (n == v);
			`UTAB_CC_LE: pass = z | (n != v);
			default: pass = 1'b1;
		endcase
	end
endmodule // utab_cond

// ### utab_div.v
// Iterative 32-bit unsigned divider, one quotient bit per clock.
`include "utab_regs.vh"
module utab_div (
	clk,
	rst_n,
	start,
	dividend,
	divisor,
	busy,
	done,
	quotient
);
	input wire clk;
	input wire rst_n;
	input wire start;
	input wire [31:0] dividend;
	input wire [31:0] divisor;
	output reg busy;
	output reg done;
	output reg [31:0] quotient;

	reg [31:0] rem;
	reg [31:0] dvs;
	reg [5:0] count;
	wire [32:0] trial = {rem[31:0], quotient[31]} - {1'b0, dvs};

	// ==========================================================================
	// Restoring division
	// A zero divisor gives all ones quotient bits by construction; the core
	// decides whether that is trapped elsewhere.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			rem <= `UTAB_ZERO32;
			dvs <= `UTAB_ZERO32;
			quotient <= `UTAB_ZERO32;
			count <= 6'h00;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				busy <= 1'b1;
				rem <= `UTAB_ZERO32;
				dvs <= divisor;
				quotient <= dividend;
				count <= `UTAB_DIV_STEPS;
			end
			else if (busy)
			begin
				if (trial[32])
				begin
					rem <= {rem[30:0], quotient[31]};
					quotient <= {quotient[30:0], 1'b0};
				end
				else
				begin
					rem <= trial[31:0];
					quotient <= {quotient[30:0], 1'b1};
				end
				count <= count - 6'h01;
				if (count == 6'h01)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // utab_div

// ### utab_top.v
// Unsigned arithmetic and table branch execution datapath.
// How it works
// - Byte table branch reads byte at base plus index, branches forward twice it.
// - Halfword table branch reads halfword at base plus index times two, branches twice it.
// - Table branches exist only in the 32-bit compact encoding.
// - Packed byte add performs four independent 8-bit lane additions.
// - Packed halfword add performs two independent 16-bit lane additions.
// - Add-sub-exchange swaps second operand halves, adds tops, subtracts bottoms.
// - Bitfield extract moves width bits from lsb to bit zero, zero-filled.
// - Unsigned divide writes 32-bit quotient of dividend by divisor; optional.
// - Halving adds add byte or halfword lanes and halve each result.
// - Halving exchange forms swap halves, add/subtract crosswise, halve each result.
// - Halving subtracts subtract byte or halfword lanes and halve each result.
// - Double-accumulate multiply adds product and both destination words into pair.
// - Multiply-accumulate long adds 64-bit product to destination pair.
// - Multiply long writes low product word low, high word high.
// - Flag option on long multiplies updates flags from result, else unchanged.
// - Saturating byte add clamps lanes to 0..255, sticky saturation untouched.
`include "utab_regs.vh"
module utab_top (
	CLK,
	ARST_N,
	ISSUE_VALID,
	ISSUE_READY,
	OPCODE,
	COND,
	WIDE_ENC,
	SET_FLAGS,
	FLAGS_IN,
	OP_A,
	OP_B,
	DEST_LO_IN,
	DEST_HI_IN,
	LSB,
	WIDTH,
	PC,
	DIV_PRESENT,
	MEM_REQ,
	MEM_ADDR,
	MEM_HALF,
	MEM_ACK,
	MEM_RDATA,
	RESULT_VALID,
	RESULT_LO,
	RESULT_HI,
	WRITE_LO,
	WRITE_HI,
	FLAGS_WRITE,
	FLAGS_OUT,
	BRANCH_TAKEN,
	BRANCH_TARGET,
	UNDEFINED
);
	input wire CLK;
	input wire ARST_N;
	input wire ISSUE_VALID;
	output wire ISSUE_READY;
	input wire [`UTAB_OP_W-1:0] OPCODE;
	input wire [3:0] COND;
	input wire WIDE_ENC;
	input wire SET_FLAGS;
	input wire [3:0] FLAGS_IN;
	input wire [31:0] OP_A;
	input wire [31:0] OP_B;
	input wire [31:0] DEST_LO_IN;
	input wire [31:0] DEST_HI_IN;
	input wire [4:0] LSB;
	input wire [5:0] WIDTH;
	input wire [31:0] PC;
	input wire DIV_PRESENT;
	output reg MEM_REQ;
	output reg [31:0] MEM_ADDR;
	output reg MEM_HALF;
	input wire MEM_ACK;
	input wire [15:0] MEM_RDATA;
	output reg RESULT_VALID;
	output reg [31:0] RESULT_LO;
	output reg [31:0] RESULT_HI;
	output reg WRITE_LO;
	output reg WRITE_HI;
	output reg FLAGS_WRITE;
	output reg [3:0] FLAGS_OUT;
	output reg BRANCH_TAKEN;
	output reg [31:0] BRANCH_TARGET;
	output reg UNDEFINED;

	localparam ST_IDLE = 2'h0;
	localparam ST_MEM = 2'h1;
	localparam ST_DIV = 2'h2;

	reg rst_meta;
	reg rst_n;
	reg [1:0] state;
	wire cond_pass;
	wire div_busy;
	wire div_done;
	wire [31:0] div_quot;

	// ==========================================================================
	// Lane helpers
	// Byte lane add or subtract keeping the ninth bit for halving.
	function [8:0] lane8;
		input [7:0] a;
		input [7:0] b;
		input sub;
		begin
			lane8 = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
		end
	endfunction

	// Halfword lane add or subtract keeping the seventeenth bit.
	function [16:0] lane16;
		input [15:0] a;
		input [15:0] b;
		input sub;
		begin
			lane16 = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
		end
	endfunction

	// Four byte lanes; halve shifts each nine-bit result right by one.
	function [31:0] bytes4;
		input [31:0] a;
		input [31:0] b;
		input sub;
		input halve;
		input sat;
		reg [8:0] r;
		integer i;
		begin
			bytes4 = `UTAB_ZERO32;
			for (i = 0; i < 4; i = i + 1)
			begin
				r = lane8(a[i*8 +: 8], b[i*8 +: 8], sub);
				if (halve)
					bytes4[i*8 +: 8] = r[8:1];
				else if (sat && r[8])
					bytes4[i*8 +: 8] = `UTAB_SAT8;
				else
					bytes4[i*8 +: 8] = r[7:0];
			end
		end
	endfunction

	// Two halfword lanes with separate add/subtract choice per lane.
	function [31:0] halves2;
		input [31:0] a;
		input [31:0] b;
		input sub_hi;
		input sub_lo;
		input halve;
		reg [16:0] h;
		reg [16:0] l;
		begin
			h = lane16(a[31:16], b[31:16], sub_hi);
			l = lane16(a[15:0], b[15:0], sub_lo);
			halves2 = halve ? {h[16:1], l[16:1]} : {h[15:0], l[15:0]};
		end
	endfunction

	// ==========================================================================
	// Reset release and submodules
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	utab_cond u_cond (
		.cond(COND),
		.flags(FLAGS_IN),
		.pass(cond_pass)
	);

	wire div_start = (state == ST_IDLE) && ISSUE_VALID && cond_pass && DIV_PRESENT &&
		(OPCODE == `UTAB_OP_UNSIGNED_DIVIDE);

	utab_div u_div (
		.clk(CLK),
		.rst_n(rst_n),
		.start(div_start),
		.dividend(OP_A),
		.divisor(OP_B),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_quot)
	);

	// ==========================================================================
	// Single-cycle results
	wire [31:0] b_swap = {OP_B[15:0], OP_B[31:16]};
	wire [63:0] product = {`UTAB_ZERO32, OP_A} * {`UTAB_ZERO32, OP_B};
	wire [63:0] acc_long = product + {DEST_HI_IN, DEST_LO_IN};
	wire [63:0] acc_double = product + {32'h00000000, DEST_HI_IN} + {32'h00000000, DEST_LO_IN};
	wire [31:0] field_mask = (WIDTH >= 6'h20) ? `UTAB_ONES32 :
		~(`UTAB_ONES32 << WIDTH);
	wire [31:0] field = (OP_A >> LSB) & field_mask;
	reg [63:0] next_result;
	reg next_lo;
	reg next_hi;
	reg next_flags;
	reg next_undef;

	// Picks the result and which destination words are written.
	always @*
	begin
		next_result = 64'h0000000000000000;
		next_lo = 1'b1;
		next_hi = 1'b0;
		next_flags = 1'b0;
		next_undef = 1'b0;
		case (OPCODE)
			`UTAB_OP_PACKED_BYTE_ADD:
				next_result[31:0] = bytes4(OP_A, OP_B, 1'b0, 1'b0, 1'b0);
			`UTAB_OP_PACKED_HALF_ADD:
				next_result[31:0] = halves2(OP_A, OP_B, 1'b0, 1'b0, 1'b0);
			`UTAB_OP_ADD_SUB_EXCHANGE:
				next_result[31:0] = halves2(OP_A, b_swap, 1'b0, 1'b1, 1'b0);
			`UTAB_OP_BITFIELD_EXTRACT_ZERO:
				next_result[31:0] = field;
			`UTAB_OP_HALVING_BYTE_ADD:
				next_result[31:0] = bytes4(OP_A, OP_B, 1'b0, 1'b1, 1'b0);
			`UTAB_OP_HALVING_HALF_ADD:
				next_result[31:0] = halves2(OP_A, OP_B, 1'b0, 1'b0, 1'b1);
			`UTAB_OP_HALVING_ADD_SUB_EXCHANGE:
				next_result[31:0] = halves2(OP_A, b_swap, 1'b0, 1'b1, 1'b1);
			`UTAB_OP_HALVING_SUB_ADD_EXCHANGE:
				next_result[31:0] = halves2(OP_A, b_swap, 1'b1, 1'b0, 1'b1);
			`UTAB_OP_HALVING_BYTE_SUB:
				next_result[31:0] = bytes4(OP_A, OP_B, 1'b1, 1'b1, 1'b0);
			`UTAB_OP_HALVING_HALF_SUB:
				next_result[31:0] = halves2(OP_A, OP_B, 1'b1, 1'b1, 1'b1);
			`UTAB_OP_SATURATING_BYTE_ADD:
				next_result[31:0] = bytes4(OP_A, OP_B, 1'b0, 1'b0, 1'b1);
			`UTAB_OP_DOUBLE_ACCUMULATE_MULTIPLY:
			begin
				next_result = acc_double;
				next_hi = 1'b1;
			end
			`UTAB_OP_MULTIPLY_ACCUMULATE_LONG:
			begin
				next_result = acc_long;
				next_hi = 1'b1;
				next_flags = SET_FLAGS;
			end
			`UTAB_OP_MULTIPLY_LONG:
			begin
				next_result = product;
				next_hi = 1'b1;
				next_flags = SET_FLAGS;
			end
			default:
			begin
				next_lo = 1'b0;
				next_undef = 1'b1;
			end
		endcase
	end

	wire is_table = (OPCODE == `UTAB_OP_BYTE_TABLE_BRANCH) ||
		(OPCODE == `UTAB_OP_HALFWORD_TABLE_BRANCH);
	wire is_div = (OPCODE == `UTAB_OP_UNSIGNED_DIVIDE);
	assign ISSUE_READY = (state == ST_IDLE);

	// ==========================================================================
	// Issue and completion
	// One instruction in flight; table branches and divides hold the issue
	// port until their memory read or quotient is ready.
	always @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			MEM_REQ <= 1'b0;
			MEM_ADDR <= `UTAB_ZERO32;
			MEM_HALF <= 1'b0;
			RESULT_VALID <= 1'b0;
			RESULT_LO <= `UTAB_ZERO32;
			RESULT_HI <= `UTAB_ZERO32;
			WRITE_LO <= 1'b0;
			WRITE_HI <= 1'b0;
			FLAGS_WRITE <= 1'b0;
			FLAGS_OUT <= 4'h0;
			BRANCH_TAKEN <= 1'b0;
			BRANCH_TARGET <= `UTAB_ZERO32;
			UNDEFINED <= 1'b0;
		end
		else
		begin
			RESULT_VALID <= 1'b0;
			WRITE_LO <= 1'b0;
			WRITE_HI <= 1'b0;
			FLAGS_WRITE <= 1'b0;
			BRANCH_TAKEN <= 1'b0;
			UNDEFINED <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (ISSUE_VALID)
					begin
						if (!cond_pass)
							RESULT_VALID <= 1'b1;
						else if (is_table)
						begin
							if (!WIDE_ENC)
							begin
								RESULT_VALID <= 1'b1;
								UNDEFINED <= 1'b1;
							end
							else
							begin
								MEM_REQ <= 1'b1;
								MEM_HALF <= (OPCODE == `UTAB_OP_HALFWORD_TABLE_BRANCH);
								if (OPCODE == `UTAB_OP_HALFWORD_TABLE_BRANCH)
									MEM_ADDR <= OP_A + {OP_B[30:0], 1'b0};
								else
									MEM_ADDR <= OP_A + OP_B;
								BRANCH_TARGET <= PC;
								state <= ST_MEM;
							end
						end
						else if (is_div)
						begin
							if (DIV_PRESENT)
								state <= ST_DIV;
							else
							begin
								RESULT_VALID <= 1'b1;
								UNDEFINED <= 1'b1;
							end
						end
						else
						begin
							RESULT_VALID <= 1'b1;
							UNDEFINED <= next_undef;
							RESULT_LO <= next_result[31:0];
							RESULT_HI <= next_result[63:32];
							WRITE_LO <= next_lo;
							WRITE_HI <= next_hi;
							FLAGS_WRITE <= next_flags;
							FLAGS_OUT <= {next_result[63], (next_result == 64'h0000000000000000),
								FLAGS_IN[`UTAB_FLAG_C], FLAGS_IN[`UTAB_FLAG_V]};
						end
					end
				end
				ST_MEM:
				begin
					if (MEM_ACK)
					begin
						MEM_REQ <= 1'b0;
						RESULT_VALID <= 1'b1;
						BRANCH_TAKEN <= 1'b1;
						if (MEM_HALF)
							BRANCH_TARGET <= BRANCH_TARGET + {15'h0000, MEM_RDATA, 1'b0};
						else
							BRANCH_TARGET <= BRANCH_TARGET + {23'h000000, MEM_RDATA[7:0], 1'b0};
						state <= ST_IDLE;
					end
				end
				ST_DIV:
				begin
					if (div_done && !div_busy)
					begin
						RESULT_VALID <= 1'b1;
						RESULT_LO <= div_quot;
						WRITE_LO <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // utab_top

// ### utab_top_sva.sv
// Concurrent checks on the ports of the unsigned datapath top module.
`include "utab_regs.vh"
module utab_top_sva (
	input wire CLK,
	input wire ARST_N,
	input wire ISSUE_VALID,
	input wire ISSUE_READY,
	input wire [4:0] OPCODE,
	input wire [3:0] COND,
	input wire WIDE_ENC,
	input wire SET_FLAGS,
	input wire [3:0] FLAGS_IN,
	input wire [31:0] OP_A,
	input wire [31:0] OP_B,
	input wire [31:0] DEST_LO_IN,
	input wire [31:0] DEST_HI_IN,
	input wire [31:0] PC,
	input wire MEM_REQ,
	input wire [31:0] MEM_ADDR,
	input wire MEM_HALF,
	input wire MEM_ACK,
	input wire [15:0] MEM_RDATA,
	input wire RESULT_VALID,
	input wire [31:0] RESULT_LO,
	input wire [31:0] RESULT_HI,
	input wire WRITE_LO,
	input wire FLAGS_WRITE,
	input wire BRANCH_TAKEN,
	input wire [31:0] BRANCH_TARGET
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================================
	// Helper logic
	wire take = ISSUE_VALID && ISSUE_READY && COND == 4'he && WIDE_ENC;
	reg go;
	reg sf;
	reg [4:0] op;
	reg [31:0] a, b, lo, hi, pc, tv;
	wire [63:0] prod = {32'h0, a} * {32'h0, b};
	wire tbr = op == `UTAB_OP_BYTE_TABLE_BRANCH || op == `UTAB_OP_HALFWORD_TABLE_BRANCH;
	function [7:0] s8(input [8:0] x);
		s8 = x[8] ? 8'hff : x[7:0];
	endfunction
	// Marks the cycle in which an always-executed issue must be answered.
	always @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			go <= 1'b0;
		else
			go <= take;
	end
	// Keeps the operands of the last issue and the table value of the last read.
	always @(posedge CLK)
	begin
		if (take)
			{op, sf, a, b, lo, hi, pc} <= {OPCODE, SET_FLAGS, OP_A, OP_B, DEST_LO_IN, DEST_HI_IN, PC};
		if (MEM_REQ && MEM_ACK)
			tv <= MEM_HALF ? {16'h0, MEM_RDATA} : {24'h0, MEM_RDATA[7:0]};
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	// ==========================================================================
	// Assertions
	a_mul_long_words: assert property (go && op == `UTAB_OP_MULTIPLY_LONG |->
		RESULT_VALID && WRITE_LO && {RESULT_HI, RESULT_LO} == prod) else $error("multiply long");
	a_mac_long_sum: assert property (go && op == `UTAB_OP_MULTIPLY_ACCUMULATE_LONG |->
		{RESULT_HI, RESULT_LO} == prod + {hi, lo}) else $error("accumulate long");
	a_double_acc_sum: assert property (go && op == `UTAB_OP_DOUBLE_ACCUMULATE_MULTIPLY |->
		{RESULT_HI, RESULT_LO} == prod + lo + hi) else $error("double accumulate");
	a_long_flag_option: assert property (go && (op == `UTAB_OP_MULTIPLY_LONG ||
		op == `UTAB_OP_MULTIPLY_ACCUMULATE_LONG) |-> FLAGS_WRITE == sf) else $error("flag option");
	a_byte_add_lanes: assert property (go && op == `UTAB_OP_PACKED_BYTE_ADD |-> RESULT_LO ==
		{a[31:24] + b[31:24], a[23:16] + b[23:16], a[15:8] + b[15:8], a[7:0] + b[7:0]})
		else $error("byte add lanes");
	a_sat_byte_clamp: assert property (go && op == `UTAB_OP_SATURATING_BYTE_ADD |->
		RESULT_LO == {s8({1'b0, a[31:24]} + b[31:24]), s8({1'b0, a[23:16]} + b[23:16]),
		s8({1'b0, a[15:8]} + b[15:8]), s8({1'b0, a[7:0]} + b[7:0])}) else $error("saturating add");
	a_table_read_addr: assert property (go && tbr |-> MEM_REQ &&
		MEM_HALF == (op == `UTAB_OP_HALFWORD_TABLE_BRANCH) &&
		MEM_ADDR == a + (MEM_HALF ? b << 1 : b)) else $error("table read address");
	a_branch_target: assert property (MEM_REQ && MEM_ACK |=> BRANCH_TAKEN && RESULT_VALID &&
		!MEM_REQ && BRANCH_TARGET == pc + (tv << 1)) else $error("branch target");
	a_false_cond_quiet: assert property (ISSUE_VALID && ISSUE_READY && COND == `UTAB_CC_EQ &&
		!FLAGS_IN[`UTAB_FLAG_Z] |=> RESULT_VALID && !WRITE_LO && !FLAGS_WRITE && !BRANCH_TAKEN
		&& !MEM_REQ) else $error("failed condition wrote");
	c_divide: cover property (go && op == `UTAB_OP_UNSIGNED_DIVIDE);
	c_half_read: cover property (MEM_REQ && MEM_ACK && MEM_HALF);
	c_quiet: cover property (RESULT_VALID && !WRITE_LO);
endmodule // utab_top_sva

bind utab_top utab_top_sva utab_top_sva_inst (.CLK(CLK), .ARST_N(ARST_N), .ISSUE_VALID(ISSUE_VALID),
	.ISSUE_READY(ISSUE_READY), .OPCODE(OPCODE), .COND(COND), .WIDE_ENC(WIDE_ENC),
	.SET_FLAGS(SET_FLAGS), .FLAGS_IN(FLAGS_IN), .OP_A(OP_A), .OP_B(OP_B), .PC(PC),
	.DEST_LO_IN(DEST_LO_IN), .DEST_HI_IN(DEST_HI_IN), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
	.MEM_HALF(MEM_HALF), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .RESULT_VALID(RESULT_VALID),
	.RESULT_LO(RESULT_LO), .RESULT_HI(RESULT_HI), .WRITE_LO(WRITE_LO), .FLAGS_WRITE(FLAGS_WRITE),
	.BRANCH_TAKEN(BRANCH_TAKEN), .BRANCH_TARGET(BRANCH_TARGET));

// ### utab_mem_model.sv
// Table memory model that answers table reads after a chosen number of wait cycles.
module utab_mem_model (
	input wire clk,
	input wire rst_n,
	input wire req,
	input wire [31:0] addr,
	input wire half,
	input wire [3:0] wait_n,
	output reg ack,
	output reg [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [3:0] cnt;
	wire [7:0] lo = addr[7:0] ^ 8'h5a;
	// Acknowledge once the wait runs out; outside the ack the data lines toggle every cycle.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{ack, cnt, rdata} <= 21'h0;
		else if (req && !ack && cnt == wait_n)
		begin
			ack <= 1'b1;
			rdata <= half ? {addr[7:0] ^ 8'h3c, lo} : {~lo, lo};
		end
		else
		begin
			ack <= 1'b0;
			cnt <= req && !ack ? cnt + 4'h1 : 4'h0;
			rdata <= ~rdata;
		end
	end
endmodule // utab_mem_model

// ### tb_unsigned_arith_table_branch.sv
// Self-checking bench for the unsigned datapath with its table memory model.
`include "utab_regs.vh"
module tb_unsigned_arith_table_branch;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [4:0] op; logic [31:0] a, b, lo, hi, elo, ehi;} utab_row;
	logic clk = 1'b0, arst_n = 1'b0, iv = 1'b0, sf = 1'b0, wide = 1'b1, divp = 1'b1;
	logic [4:0] op = 5'h0;
	logic [3:0] cond = 4'he, fin = 4'h0, mw = 4'h0;
	logic [31:0] a = 32'h0, b = 32'h0, dlo = 32'h0, dhi = 32'h0, pc = 32'h200;
	wire rdy, mreq, mhalf, mack, rv, wlo, whi, fw, bt, und;
	wire [31:0] maddr, rlo, rhi, btgt;
	wire [15:0] mrd;
	wire [3:0] fout;
	int mismatches = 0, n_tests = 0, i, k;
	// Rows: operation, operands, destination inputs (also lsb and width), low and high results.
	utab_row rows [17] = '{
		'{5'h03, 32'h80ff0102, 32'h80020304, 32'h0, 32'h0, 32'h00010406, 32'h0},
		'{5'h04, 32'hffff0001, 32'h00020003, 32'h0, 32'h0, 32'h00010004, 32'h0},
		'{5'h05, 32'h10000005, 32'h00070003, 32'h0, 32'h0, 32'h1003fffe, 32'h0},
		'{5'h06, 32'hdeadbeef, 32'h0, 32'h8, 32'hc, 32'h00000dbe, 32'h0},
		'{5'h06, 32'hdeadbeef, 32'h0, 32'h0, 32'h20, 32'hdeadbeef, 32'h0},
		'{5'h07, 32'h64, 32'h7, 32'h0, 32'h0, 32'he, 32'h0},
		'{5'h07, 32'h5, 32'h0, 32'h0, 32'h0, 32'hffffffff, 32'h0},
		'{5'h08, 32'hff800301, 32'hff800102, 32'h0, 32'h0, 32'hff800201, 32'h0},
		'{5'h09, 32'hffff0003, 32'h00010004, 32'h0, 32'h0, 32'h80000003, 32'h0},
		'{5'h0a, 32'h00100004, 32'h00060002, 32'h0, 32'h0, 32'h0009ffff, 32'h0},
		'{5'h0b, 32'h00100004, 32'h00060002, 32'h0, 32'h0, 32'h00070005, 32'h0},
		'{5'h0c, 32'h10010800, 32'h02030402, 32'h0, 32'h0, 32'h07ff02ff, 32'h0},
		'{5'h0d, 32'h00010010, 32'h00030004, 32'h0, 32'h0, 32'hffff0006, 32'h0},
		'{5'h0e, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff},
		'{5'h0f, 32'h00010000, 32'h00010000, 32'hffffffff, 32'h2, 32'hffffffff, 32'h3},
		'{5'h10, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0, 32'h00000001, 32'hfffffffe},
		'{5'h11, 32'h80fe0110, 32'h80010220, 32'h0, 32'h0, 32'hffff0330, 32'h0}};
	utab_top utab_top_inst (.CLK(clk), .ARST_N(arst_n), .ISSUE_VALID(iv), .ISSUE_READY(rdy),
		.OPCODE(op), .COND(cond), .WIDE_ENC(wide), .SET_FLAGS(sf), .FLAGS_IN(fin), .OP_A(a),
		.OP_B(b), .DEST_LO_IN(dlo), .DEST_HI_IN(dhi), .LSB(dlo[4:0]), .WIDTH(dhi[5:0]), .PC(pc),
		.DIV_PRESENT(divp), .MEM_REQ(mreq), .MEM_ADDR(maddr), .MEM_HALF(mhalf), .MEM_ACK(mack),
		.MEM_RDATA(mrd), .RESULT_VALID(rv), .RESULT_LO(rlo), .RESULT_HI(rhi), .WRITE_LO(wlo),
		.WRITE_HI(whi), .FLAGS_WRITE(fw), .FLAGS_OUT(fout), .BRANCH_TAKEN(bt),
		.BRANCH_TARGET(btgt), .UNDEFINED(und));
	utab_mem_model utab_mem_model_inst (.clk(clk), .rst_n(arst_n), .req(mreq), .addr(maddr),
		.half(mhalf), .wait_n(mw), .ack(mack), .rdata(mrd));
	// Clock of 50 ns period.
	always #25 clk = ~clk;
	// ==========================================================================
	// Tasks
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Present one instruction for one edge, then wait a bounded time for its result pulse.
	task issue(input logic [4:0] o, input logic [31:0] x, y, l, h);
		@(posedge clk);
		{iv, op, a, b, dlo, dhi} <= {1'b1, o, x, y, l, h};
		@(posedge clk);
		iv <= 1'b0;
		k = 0;
		#1;
		while (rv !== 1'b1 && k < 60)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(rv, 1'b1);
	endtask
	// Table branch; the expected table value follows the memory model's contents.
	task br(input logic h, input logic [31:0] x, y, input logic [3:0] w);
		logic [31:0] ad;
		logic [15:0] v;
		ad = h ? x + (y << 1) : x + y;
		v = h ? {ad[7:0] ^ 8'h3c, ad[7:0] ^ 8'h5a} : {8'h0, ad[7:0] ^ 8'h5a};
		mw <= w;
		issue(h ? `UTAB_OP_HALFWORD_TABLE_BRANCH : `UTAB_OP_BYTE_TABLE_BRANCH, x, y, 0, 0);
		chk({bt, btgt}, {1'b1, pc + {v, 1'b0}});
	endtask
	// ==========================================================================
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 17; i++)
		begin
			issue(rows[i].op, rows[i].a, rows[i].b, rows[i].lo, rows[i].hi);
			chk({wlo, fw, rlo}, {2'b10, rows[i].elo});
			if (rows[i].op >= 5'h0e && rows[i].op <= 5'h10)
				chk({whi, rhi}, {1'b1, rows[i].ehi});
		end
		$display("operation table done");
		{sf, fin} <= 5'h13;
		issue(`UTAB_OP_MULTIPLY_LONG, 32'h0, 32'h5, 32'h0, 32'h0);
		chk({fw, fout}, 5'h17);
		fin <= 4'h0;
		issue(`UTAB_OP_MULTIPLY_ACCUMULATE_LONG, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0);
		chk({fw, fout, rhi, rlo}, {5'h18, 64'hfffffffe00000001});
		cond <= `UTAB_CC_EQ;
		issue(`UTAB_OP_PACKED_BYTE_ADD, 32'h1, 32'h1, 32'h0, 32'h0);
		chk({wlo, fw, bt}, 3'h0);
		issue(`UTAB_OP_BYTE_TABLE_BRANCH, 32'h1000, 32'h1, 32'h0, 32'h0);
		chk({bt, mreq}, 2'h0);
		{sf, cond} <= {1'b0, 4'he};
		$display("flag and condition tests done");
		br(1'b0, 32'h1000, 32'h5, 4'h0);
		br(1'b0, 32'h1000, 32'ha5, 4'h2);
		pc <= 32'h00401000;
		br(1'b1, 32'h1000, 32'hfff0, 4'h3);
		wide <= 1'b0;
		issue(`UTAB_OP_HALFWORD_TABLE_BRANCH, 32'h1000, 32'h1, 32'h0, 32'h0);
		chk({und, mreq, bt}, 3'h4);
		{wide, divp} <= 2'b10;
		issue(`UTAB_OP_UNSIGNED_DIVIDE, 32'h64, 32'h7, 32'h0, 32'h0);
		chk({und, wlo}, 2'h2);
		issue(5'h12, 32'h1, 32'h1, 32'h0, 32'h0);
		chk({und, wlo, whi, fw}, 4'h8);
		divp <= 1'b1;
		@(posedge clk);
		{iv, op, a, b} <= {1'b1, `UTAB_OP_UNSIGNED_DIVIDE, 32'h9, 32'h3};
		@(posedge clk);
		iv <= 1'b0;
		#1;
		chk(rdy, 1'b0);
		repeat (40) @(posedge clk);
		#1;
		chk({rdy, wlo, rlo}, {2'b10, 32'h3});
		$display("table branch and undefined tests done");
		arst_n <= 1'b0;
		@(posedge clk);
		#1;
		chk({rv, wlo, mreq, bt, fw, und}, 6'h0);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		issue(`UTAB_OP_PACKED_HALF_ADD, 32'h00010002, 32'h00030004, 32'h0, 32'h0);
		chk(rlo, 32'h00040006);
		$display("reset test done");
		end_sim;
	end
	// Cut a hung run short after 4000 cycles.
	initial
	begin
		#200000;
		mismatches++;
		end_sim;
	end
endmodule // tb_unsigned_arith_table_branch
